/* File: tx_queue_manual_release.sv */
/*
 * Transmit queue manager with manual release: page allocation, transmit
 * FIFO, completion FIFO, status write-back, interrupts, Wishbone registers.
 * Assumes a MAC that takes mac_start_o and answers with one mac_done_i pulse.
 */
`include "txq_cfg.svh"
`default_nettype none

module tx_queue_manual_release
    import txq_pkg::*;
#(
    parameter int NPKT   = 32,
    parameter int NPAGES = 32
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic        wb_we_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    output var  logic [31:0] wb_dat_o,
    output var  logic        wb_ack_o,
    output logic             irq_o,
    input  wire logic        full_duplex_i,
    input  wire logic        defer_ok_i,
    output logic             mac_start_o,
    output var  logic [5:0]  mac_pkt_o,
    input  wire logic        mac_done_i,
    input  wire mac_result_t mac_result_i
);

    localparam int PW = $clog2(NPKT);
    localparam int CW = $clog2(NPAGES + 1);

    generate
        if (NPKT < 2 || NPKT > 64 || (NPKT & (NPKT - 1)) != 0 || NPAGES < 1 || NPAGES > 255)
        begin : g_bad
            $error("tx_queue_manual_release: unsupported NPKT or NPAGES");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode

    logic          acc;
    logic          wr;
    logic [2:0]    cmd_code;
    logic [15:0]   cmd_len;
    logic          wr_cmd;
    logic          do_alloc;
    logic          do_enq;
    logic          do_rel;
    logic          wr_pkt;
    logic          wr_ack;
    logic          wr_int;
    logic          wr_mask;
    logic          wr_tcr;

    assign acc      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr       = acc & wb_we_i & wb_sel_i[0];
    assign cmd_code = wb_dat_i[`CMD_CODE_LSB +: 3];
    assign cmd_len  = wb_dat_i[`CMD_LEN_LSB +: 16];
    assign wr_cmd   = wr & (wb_adr_i == `OFS_CMD);
    assign do_alloc = wr_cmd & (cmd_code == `CMD_ALLOC);
    assign do_enq   = wr_cmd & (cmd_code == `CMD_ENQUEUE);
    assign do_rel   = wr_cmd & (cmd_code == `CMD_RELEASE);
    assign wr_pkt   = wr & (wb_adr_i == `OFS_PKT_NUM);
    assign wr_ack   = wr & (wb_adr_i == `OFS_TX_ACK);
    assign wr_int   = wr & (wb_adr_i == `OFS_INT_STATUS);
    assign wr_mask  = wr & (wb_adr_i == `OFS_INT_MASK);
    assign wr_tcr   = wr & (wb_adr_i == `OFS_TX_CTRL);

    ////////////////////////////////////////////////////////////////////////////
    // Page allocation

    logic [NPKT-1:0] in_use;
    logic [8:0]      pages_of [NPKT];
    logic [CW-1:0]   free_pages;
    alloc_result_t   alloc_res;
    logic [PW-1:0]   pkt_num;

    logic [8:0]      need_pages;
    logic [PW-1:0]   free_slot;
    logic            slot_found;
    logic            alloc_ok;
    logic            rel_ok;

    assign need_pages = 9'((17'(cmd_len) + 17'(255)) >> `PAGE_SHIFT);

    always_comb
    begin
        free_slot  = '0;
        slot_found = 1'b0;
        for (int i = NPKT - 1; i >= 0; i--)
        begin
            if (!in_use[i])
            begin
                free_slot  = PW'(i);
                slot_found = 1'b1;
            end
        end
    end

    assign alloc_ok = do_alloc & slot_found & (need_pages <= 9'(free_pages));
    assign rel_ok   = do_rel & in_use[pkt_num];

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            in_use     <= '0;
            free_pages <= CW'(NPAGES);
            alloc_res  <= `RST_ALLOC_RES;
        end
        else
        begin
            if (rel_ok)
            begin
                in_use[pkt_num] <= 1'b0;
                free_pages      <= free_pages + CW'(pages_of[pkt_num]);
            end
            else if (alloc_ok)
            begin
                in_use[free_slot] <= 1'b1;
                free_pages        <= free_pages - CW'(need_pages);
            end
            if (do_alloc)
            begin
                alloc_res.fail <= ~alloc_ok;
                alloc_res.pkt  <= 6'(free_slot);
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (alloc_ok && !rel_ok)
        begin
            pages_of[free_slot] <= need_pages;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Transmit FIFO and completion FIFO

    logic [PW-1:0] txq [NPKT];
    logic [PW-1:0] cmpq [NPKT];
    logic [PW:0]   tx_wp;
    logic [PW:0]   tx_rp;
    logic [PW:0]   cq_wp;
    logic [PW:0]   cq_rp;
    logic          tx_empty;
    logic          tx_full;
    logic          cq_empty;
    logic          cq_full;
    logic          tx_push;
    logic          tx_pop;
    logic          cq_pop;
    logic [PW-1:0] tx_head;
    logic [PW-1:0] cq_head;

    assign tx_empty = (tx_wp == tx_rp);
    assign tx_full  = (tx_wp == {~tx_rp[PW], tx_rp[PW-1:0]});
    assign cq_empty = (cq_wp == cq_rp);
    assign cq_full  = (cq_wp == {~cq_rp[PW], cq_rp[PW-1:0]});
    assign tx_head  = txq[tx_rp[PW-1:0]];
    assign cq_head  = cmpq[cq_rp[PW-1:0]];
    assign tx_push  = do_enq & ~tx_full;
    assign cq_pop   = wr_ack & ~cq_empty;

    ////////////////////////////////////////////////////////////////////////////
    // Transmit sequencer

    mac_state_t state;
    mac_state_t next_state;
    logic       tx_enable_bit;
    logic       can_start;
    logic       done_ok;
    logic       done_fail;

    assign can_start   = tx_enable_bit & ~tx_empty & (full_duplex_i | defer_ok_i);
    assign mac_start_o = (state == MAC_IDLE) & can_start;
    assign done_ok     = (state == MAC_BUSY) & mac_done_i & ~cq_full & ~mac_result_i.fail;
    assign done_fail   = (state == MAC_BUSY) & mac_done_i & ~cq_full & mac_result_i.fail;
    assign tx_pop      = (state == MAC_BUSY) & mac_done_i & ~cq_full;

    always_comb
    begin
        next_state = state;
        case (state)
            MAC_IDLE: if (can_start) next_state = MAC_BUSY;
            MAC_BUSY: if (done_fail) next_state = MAC_HALT;
                      else if (done_ok) next_state = MAC_IDLE;
            MAC_HALT: if (tx_enable_bit) next_state = MAC_IDLE;
            default:  next_state = MAC_IDLE;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state         <= MAC_IDLE;
            tx_enable_bit <= `RST_TX_ENABLE;
            tx_wp         <= '0;
            tx_rp         <= '0;
            cq_wp         <= '0;
            cq_rp         <= '0;
            mac_pkt_o     <= '0;
        end
        else
        begin
            state <= next_state;
            if (done_fail)
            begin
                tx_enable_bit <= 1'b0;
            end
            else if (wr_tcr)
            begin
                tx_enable_bit <= wb_dat_i[`TCR_TX_ENABLE];
            end
            if (tx_push)
            begin
                txq[tx_wp[PW-1:0]] <= pkt_num;
                tx_wp              <= tx_wp + 1'b1;
            end
            if (tx_pop)
            begin
                cmpq[cq_wp[PW-1:0]] <= tx_head;
                cq_wp               <= cq_wp + 1'b1;
                tx_rp               <= tx_rp + 1'b1;
            end
            if (cq_pop)
            begin
                cq_rp <= cq_rp + 1'b1;
            end
            if (mac_start_o)
            begin
                mac_pkt_o <= 6'(tx_head);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Status write-back and packet number register

    logic [15:0] status_rd;
    logic [15:0] link_side_status_reg;

    txq_status_mem #(
        .DEPTH (NPKT),
        .WIDTH (16)
    ) u_status_mem (
        .clk_i   (clk_i),
        .we_i    (tx_pop),
        .waddr_i (tx_head),
        .wdata_i (mac_result_i.status),
        .raddr_i (pkt_num),
        .rdata_o (status_rd)
    );

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pkt_num              <= '0;
            link_side_status_reg <= '0;
        end
        else
        begin
            if (wr_pkt)
            begin
                pkt_num <= wb_dat_i[PW-1:0];
            end
            if (tx_pop)
            begin
                link_side_status_reg <= mac_result_i.status;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupts

    logic [3:0] int_stat;
    logic [3:0] int_mask;
    logic [3:0] int_set;
    logic [3:0] int_view;

    assign int_set[`INT_ALLOC]    = alloc_ok;
    assign int_set[`INT_TX]       = 1'b0;
    assign int_set[`INT_TX_FAIL]  = done_fail;
    assign int_set[`INT_TX_EMPTY] = done_ok & (tx_wp == tx_rp + 1'b1);

    assign int_view = {int_stat[3:2], ~cq_empty, int_stat[0]};
    assign irq_o    = |(int_view & int_mask);

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            int_stat <= '0;
            int_mask <= `RST_INT_MASK;
        end
        else
        begin
            int_stat <= (int_stat & ~(wr_int ? wb_dat_i[3:0] : 4'h0)) | int_set;
            if (wr_mask)
            begin
                int_mask <= wb_dat_i[3:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read mux and acknowledge

    logic [31:0] rd_data;
    logic [31:0] ports_word;

    assign ports_word = {16'h0000, tx_empty, 7'(tx_head), cq_empty, 7'(cq_head)};

    assign rd_data = (wb_adr_i == `OFS_ALLOC_RES)   ? {24'h000000, alloc_res.fail, 1'b0, alloc_res.pkt} :
                     (wb_adr_i == `OFS_PKT_NUM)     ? 32'(pkt_num) :
                     (wb_adr_i == `OFS_FIFO_PORTS)  ? ports_word :
                     (wb_adr_i == `OFS_INT_STATUS)  ? {28'h0000000, int_view} :
                     (wb_adr_i == `OFS_INT_MASK)    ? {28'h0000000, int_mask} :
                     (wb_adr_i == `OFS_TX_CTRL)     ? {31'h00000000, tx_enable_bit} :
                     (wb_adr_i == `OFS_STATUS_WORD) ? {16'h0000, status_rd} :
                     (wb_adr_i == `OFS_LINK_STATUS) ? {16'h0000, link_side_status_reg} :
                     (wb_adr_i == `OFS_FREE_PAGES)  ? 32'(free_pages) :
                     32'h00000000;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end
        else
        begin
            wb_ack_o <= acc;
            if (acc && !wb_we_i)
            begin
                wb_dat_o <= rd_data;
            end
        end
    end

endmodule

`default_nettype wire

/* File: txq_cfg.svh */
/*
 * Constants of the transmit queue block: register offsets, field positions,
 * command codes and reset values.
 * Assumes byte addresses on an 8-bit Wishbone address, one 32-bit word each.
 */
// Behaviour
// - Allocate command reserves requested bytes of RAM
// - Success sets allocation flag and result number
// - Enqueue pushes packet number into transmit FIFO
// - Enqueued packet proceeds without host help
// - Start only with enable and deferral permission; full_duplex_i starts without deferral permission
// - Completion writes status word into packet memory
// - Completion moves number to completion FIFO
// - Transmit interrupt while completion FIFO non-empty
// - Failure interrupts, clears enable, halts, shows number
// - Status word readable after number is written
// - Release command returns packet pages to pool
// - Acknowledge write pops completion FIFO
`ifndef TXQ_CFG_SVH
`define TXQ_CFG_SVH

`define OFS_CMD          8'h00
`define OFS_ALLOC_RES    8'h04
`define OFS_PKT_NUM      8'h08
`define OFS_FIFO_PORTS   8'h0c
`define OFS_INT_STATUS   8'h10
`define OFS_INT_MASK     8'h14
`define OFS_TX_ACK       8'h18
`define OFS_TX_CTRL      8'h1c
`define OFS_STATUS_WORD  8'h20
`define OFS_LINK_STATUS  8'h24
`define OFS_FREE_PAGES   8'h28

`define CMD_CODE_LSB     0
`define CMD_LEN_LSB      8
`define CMD_ALLOC        3'h1
`define CMD_ENQUEUE      3'h2
`define CMD_RELEASE      3'h3

`define INT_ALLOC        0
`define INT_TX           1
`define INT_TX_FAIL      2
`define INT_TX_EMPTY     3

`define RES_FAIL_BIT     7
`define PORTS_TX_LSB     8
`define PORTS_CEMPTY_BIT 7
`define PORTS_TEMPTY_BIT 15
`define TCR_TX_ENABLE    0

`define RST_TX_ENABLE    1'b0
`define RST_INT_MASK     4'h0
// Packed fail and number fields: fail set, number zero
`define RST_ALLOC_RES    7'h40
`define PAGE_SHIFT       8

`endif

/* File: txq_pkg.sv */
/*
 * Types shared by the transmit queue block.
 * Assumes txq_cfg.svh supplies the numeric constants.
 */
`default_nettype none

package txq_pkg;

    typedef enum logic [1:0] {
        MAC_IDLE = 2'b00,
        MAC_BUSY = 2'b01,
        MAC_HALT = 2'b10
    } mac_state_t;

    typedef struct packed {
        logic        fail;
        logic [15:0] status;
    } mac_result_t;

    typedef struct packed {
        logic       fail;
        logic [5:0] pkt;
    } alloc_result_t;

endpackage

`default_nettype wire

/* File: txq_status_mem.sv */
/*
 * Per-packet status word store, one word per packet number.
 * Assumes a single clock; read data come out of a register one edge later.
 */
`default_nettype none

module txq_status_mem #(
    parameter int DEPTH = 64,
    parameter int WIDTH = 16
) (
    input  wire logic                     clk_i,
    input  wire logic                     we_i,
    input  wire logic [$clog2(DEPTH)-1:0] waddr_i,
    input  wire logic [WIDTH-1:0]         wdata_i,
    input  wire logic [$clog2(DEPTH)-1:0] raddr_i,
    output var  logic [WIDTH-1:0]         rdata_o
);

    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge clk_i)
    begin
        if (we_i)
        begin
            mem[waddr_i] <= wdata_i;
        end
        rdata_o <= mem[raddr_i];
    end

endmodule

`default_nettype wire

/* File: txq_asserts.sv */
/* Port assertions for the transmit queue block.
   Assumes one clock and a bind into every instance of the block. */
`default_nettype none
module txq_asserts
    import txq_pkg::*;
#(
    parameter int NPKT   = 32,
    parameter int NPAGES = 32
) (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic        wb_we_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        irq_o,
    input wire logic        full_duplex_i,
    input wire logic        defer_ok_i,
    input wire logic        mac_start_o,
    input wire logic [5:0]  mac_pkt_o,
    input wire logic        mac_done_i,
    input wire mac_result_t mac_result_i
);
    timeunit 1ns;
    timeprecision 1ps;
    logic busy;
    logic en;
    wire  req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire  wr0   = req & wb_we_i & wb_sel_i[0];
    wire  fdone = busy & mac_done_i & mac_result_i.fail;

    default clocking @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // Shadow of the transmission in flight and of the enable bit
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            busy <= 1'b0;
            en   <= 1'b0;
        end
        else
        begin
            busy <= mac_start_o | (busy & ~mac_done_i);
            en   <= fdone ? 1'b0 : (wr0 && wb_adr_i == 8'h1c) ? wb_dat_i[0] : en;
        end
    end
    ////////////////////////////////////////////////////////////////
    ack_resp_a: assert property (req |=> wb_ack_o)
        else $error("no ack one cycle after request");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    ack_quiet_a: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
        else $error("ack without request");
    start_defer_a: assert property (mac_start_o |-> full_duplex_i || defer_ok_i)
        else $error("start while deferral forbids");
    start_enable_a: assert property (mac_start_o |-> en)
        else $error("start while transmit disabled");
    start_busy_a: assert property (busy |-> !mac_start_o)
        else $error("start during transmission");
    pkt_hold_a: assert property (!mac_start_o |=> $stable(mac_pkt_o))
        else $error("packet number moved without start");
    mask_off_a: assert property (wr0 && wb_adr_i == 8'h14 && wb_dat_i[3:0] == 4'h0 |=> !irq_o)
        else $error("interrupt with all sources masked");

    cover property (mac_start_o);
    cover property (fdone);
    cover property (irq_o);
endmodule

bind tx_queue_manual_release txq_asserts #(.NPKT(NPKT), .NPAGES(NPAGES)) i_asserts (
    .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
    .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .irq_o(irq_o), .full_duplex_i(full_duplex_i), .defer_ok_i(defer_ok_i), .mac_start_o(mac_start_o),
    .mac_pkt_o(mac_pkt_o), .mac_done_i(mac_done_i), .mac_result_i(mac_result_i));
`default_nettype wire

/* File: tx_queue_manual_release_tb.sv */
/* Self-checking bench for the transmit queue block.
   Assumes the block's constants header and package are compiled first. */
`include "txq_cfg.svh"
`default_nettype none
module tx_queue_manual_release_tb
    import txq_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int NP = 32;
    logic        clk_i         = 1'b0;
    logic        rst_i         = 1'b1;
    logic [7:0]  wb_adr_i      = 8'h0;
    logic [31:0] wb_dat_i      = 32'h0;
    logic        wb_we_i       = 1'b0;
    logic [3:0]  wb_sel_i      = 4'h0;
    logic        wb_cyc_i      = 1'b0;
    logic        wb_stb_i      = 1'b0;
    logic        full_duplex_i = 1'b0;
    logic        defer_ok_i    = 1'b0;
    logic        mac_done_i    = 1'b0;
    mac_result_t mac_result_i  = '0;
    wire  [31:0] wb_dat_o;
    wire         wb_ack_o;
    wire         irq_o;
    wire         mac_start_o;
    wire  [5:0]  mac_pkt_o;
    int          err_count     = 0;
    int          n_checks      = 0;
    int          cycles        = 0;
    logic [31:0] q;
    logic [5:0]  pkt;

    always #2 clk_i = ~clk_i;

    tx_queue_manual_release #(.NPKT(32), .NPAGES(NP)) i_dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
        .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .irq_o(irq_o), .full_duplex_i(full_duplex_i), .defer_ok_i(defer_ok_i),
        .mac_start_o(mac_start_o), .mac_pkt_o(mac_pkt_o), .mac_done_i(mac_done_i),
        .mac_result_i(mac_result_i));
    ////////////////////////////////////////////////////////////////
    task automatic results;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e)
        begin
            $display("ERROR %s expected %h seen %h", s, e, g);
            err_count++;
        end
    endtask

    // Classic Wishbone cycle: hold until ack is sampled high, take data and release at that edge
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
        int n;
        @(posedge clk_i);
        wb_adr_i <= a;
        wb_we_i  <= w;
        wb_dat_i <= d;
        wb_sel_i <= 4'hf;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (wb_ack_o !== 1'b1 && n < 50);
        chk("bus ack", 32'h1, {31'h0, wb_ack_o});
        r = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(a, 1'b1, d, r);
    endtask

    task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        logic [31:0] r;
        bus(a, 1'b0, 32'h0, r);
        chk($sformatf("reg %h", a), e, r & m);
    endtask

    task automatic ci(input logic e);
        @(negedge clk_i);
        chk("irq", {31'h0, e}, {31'h0, irq_o});
    endtask

    task automatic nostart;
        repeat (8)
        begin
            @(negedge clk_i);
            chk("idle start", 32'h0, {31'h0, mac_start_o});
        end
    endtask

    // Waits for a start, checks the number, then ends the transmission
    task automatic send(input logic [5:0] p, input logic f, input logic [15:0] s);
        int n;
        n = 0;
        do
        begin
            @(negedge clk_i);
            n++;
        end
        while (mac_start_o !== 1'b1 && n < 100);
        chk("mac start", 32'h1, {31'h0, mac_start_o});
        @(posedge clk_i);
        @(negedge clk_i);
        chk("mac pkt", {26'h0, p}, {26'h0, mac_pkt_o});
        @(posedge clk_i);
        mac_done_i   <= 1'b1;
        mac_result_i <= {f, s};
        @(posedge clk_i);
        mac_done_i <= 1'b0;
    endtask

    always @(posedge clk_i)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            err_count++;
            results();
        end
    end
    ////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        rc(`OFS_ALLOC_RES, 32'h80, 32'hff);
        rc(`OFS_FREE_PAGES, NP, '1);
        rc(8'h3c, 32'h0, '1);
        $display("test reset done");
        // 600 bytes take three pages
        wr(`OFS_CMD, 32'h0002_5801);
        bus(`OFS_ALLOC_RES, 1'b0, 32'h0, q);
        chk("alloc fail", 32'h0, q & 32'h80);
        pkt = q[5:0];
        rc(`OFS_FREE_PAGES, NP - 3, '1);
        rc(`OFS_INT_STATUS, 32'h1, 32'h1);
        wr(`OFS_INT_MASK, 32'h1);
        ci(1'b1);
        wr(`OFS_INT_STATUS, 32'h1);
        ci(1'b0);
        $display("test alloc done");
        wr(`OFS_TX_CTRL, 32'h1);
        wr(`OFS_PKT_NUM, {26'h0, pkt});
        wr(`OFS_CMD, 32'h2);
        rc(`OFS_FIFO_PORTS, {16'h0, 2'b00, pkt, 8'h00}, 32'hff00);
        nostart();
        @(posedge clk_i);
        defer_ok_i <= 1'b1;
        send(pkt, 1'b0, 16'h1234);
        rc(`OFS_FIFO_PORTS, {16'h0, 8'h80, 2'b00, pkt}, 32'h80ff);
        rc(`OFS_INT_STATUS, 32'ha, 32'he);
        wr(`OFS_INT_MASK, 32'h2);
        ci(1'b1);
        wr(`OFS_PKT_NUM, {26'h0, pkt});
        rc(`OFS_STATUS_WORD, 32'h1234, 32'hffff);
        rc(`OFS_FREE_PAGES, NP - 3, '1);
        wr(`OFS_CMD, 32'h3);
        rc(`OFS_FREE_PAGES, NP, '1);
        wr(`OFS_TX_ACK, 32'h0);
        rc(`OFS_FIFO_PORTS, 32'h80, 32'h80);
        ci(1'b0);
        $display("test complete done");
        // Deferral held off so the start pulse cannot pass while the bench is loading
        @(posedge clk_i);
        defer_ok_i <= 1'b0;
        wr(`OFS_CMD, 32'h0001_0001);
        wr(`OFS_CMD, 32'h0001_0001);
        bus(`OFS_ALLOC_RES, 1'b0, 32'h0, q);
        chk("alloc fail", 32'h0, q & 32'h80);
        pkt = q[5:0];
        wr(`OFS_PKT_NUM, {26'h0, pkt});
        wr(`OFS_CMD, 32'h2);
        defer_ok_i <= 1'b1;
        send(pkt, 1'b1, 16'hbeef);
        rc(`OFS_TX_CTRL, 32'h0, 32'h1);
        rc(`OFS_INT_STATUS, 32'h4, 32'h4);
        rc(`OFS_FIFO_PORTS, {24'h0, 2'b00, pkt}, 32'hff);
        rc(`OFS_LINK_STATUS, 32'hbeef, 32'hffff);
        wr(`OFS_PKT_NUM, {26'h0, pkt});
        wr(`OFS_CMD, 32'h2);
        nostart();
        @(posedge clk_i);
        full_duplex_i <= 1'b1;
        defer_ok_i    <= 1'b0;
        wr(`OFS_TX_CTRL, 32'h1);
        send(pkt, 1'b0, 16'h0001);
        ci(1'b1);
        wr(`OFS_INT_MASK, 32'h0);
        ci(1'b0);
        $display("test failure done");
        results();
    end
endmodule
`default_nettype wire
